// >>> art_map.vh
// register map, field positions and constants for the split-mode reload timer
`ifndef ART_MAP_VH
`define ART_MAP_VH
// ***********************************************
// apb register byte addresses
// ***********************************************
`define ART_ADDR_CTRL 12'h000
`define ART_ADDR_CNT_LO 12'h004
`define ART_ADDR_CNT_HI 12'h008
`define ART_ADDR_RLD_LO 12'h00C
`define ART_ADDR_RLD_HI 12'h010
`define ART_ADDR_CLKCTL 12'h014
`define ART_ADDR_IRQEN 12'h018
`define ART_ADDR_STATUS 12'h01C
// ***********************************************
// control register fields
// ***********************************************
`define ART_CTL_XCLK_LO 0
`define ART_CTL_XCLK_HI 1
`define ART_CTL_RUN 2
`define ART_CTL_SPLIT 3
`define ART_CTL_LOIEN 5
`define ART_CTL_LOF 6
`define ART_CTL_HOF 7
`define ART_CTL_RST 8'h00
// clock control fields
`define ART_CK_LO 0
`define ART_CK_HI 1
// irq enable field
`define ART_IE_TMR 0
// status fields
`define ART_ST_SYNC 0
`define ART_ST_SUSP 1
// ***********************************************
// clock source encodings and timing
// ***********************************************
`define ART_XSEL_DIV12 2'h0
`define ART_XSEL_EXT8 2'h1
`define ART_XSEL_LFO 2'h3
`define ART_DIV12_MAX 4'hB
`define ART_DIV8_MAX 3'h7
`define ART_SYNC_CLKS 2'h3
`define ART_BYTE_ONES 8'hFF
`define ART_ZERO8 8'h00
`define ART_ZERO32 32'h0000_0000
`endif

// >>> art_tick.v
// clock-source selector for one counter half, one tick per count
`timescale 1ns/10ps
`include "art_map.vh"
module art_tick (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire sys_sel,
	input wire [1:0] xsel,
	input wire div12_tick,
	input wire ext8_tick,
	input wire lfo8_tick,
	output reg tick
);
	// registered tick from the chosen source; reserved code gives no tick
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tick <= 1'b0;
		end else if (ce) begin
			if (sys_sel) begin
				tick <= 1'b1;
			end else begin
				case (xsel)
					`ART_XSEL_DIV12: tick <= div12_tick;
					`ART_XSEL_EXT8: tick <= ext8_tick;
					`ART_XSEL_LFO: tick <= lfo8_tick;
					default: tick <= 1'b0;
				endcase
			end
		end
	end
endmodule

// >>> art_timer.v
// split-mode auto-reload timer with apb register access
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "art_map.vh"
// Summary of operation
// - two 8-bit bytes, split bit selects mode
// - 16-bit up count, reload pair, set high flag
// - 16-bit mode interrupts on full overflow
// - low-byte wrap interrupts when low enable set
// - split halves reload independently from own reload
// - split: run bit gates high half only
// - per-half system_clock select, else shared source select
// - split: each half sets its own flag
// - split: high irq, plus low when enabled
// - flags cleared only by software writes
// - divided clocks synchronised, in suspend as well
// - counts in suspend, overflow raises wake
// - sync busy held up to three timer clocks
// - 16-bit mode clock from system_clock, div12, ext8, lfo8
module art_timer (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ext_clk,
	input wire lfo_clk,
	input wire suspend,
	input wire wake_other,
	output reg irq_r,
	output reg wake_r
);
	// ***********************************************
	// registers
	// ***********************************************
	reg [7:0] ctrl_r;
	reg [7:0] cnt_lo_r;
	reg [7:0] cnt_hi_r;
	reg [7:0] rld_lo_r;
	reg [7:0] rld_hi_r;
	reg [1:0] clkctl_r;
	reg irqen_r;
	reg [1:0] sync_cnt_r;
	reg [3:0] div12_r;
	reg [2:0] ext_div_r;
	reg [2:0] lfo_div_r;
	reg [1:0] ext_s_r;
	reg [1:0] lfo_s_r;
	reg ext_d_r;
	reg lfo_d_r;
	reg [1:0] susp_s_r;
	reg [1:0] wko_s_r;
	reg wko_d_r;
	wire tick_lo;
	wire tick_hi;
	wire split;
	wire div12_tick;
	wire ext8_tick;
	wire lfo8_tick;
	wire wr;
	wire rd;
	wire in_susp;
	wire lo_wrap;
	wire hi_wrap;
	wire full_wrap;
	wire hi_en;
	wire lo_en;
	// ***********************************************
	// address decode
	// ***********************************************
	// true when the address names a mapped register
	function mapped;
		input [11:0] a;
		begin
			case (a)
				`ART_ADDR_CTRL, `ART_ADDR_CNT_LO, `ART_ADDR_CNT_HI, `ART_ADDR_RLD_LO,
				`ART_ADDR_RLD_HI, `ART_ADDR_CLKCTL, `ART_ADDR_IRQEN, `ART_ADDR_STATUS: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction
	assign wr = psel & penable & pwrite & pready;
	assign rd = psel & penable & ~pwrite & pready;
	assign split = ctrl_r[`ART_CTL_SPLIT];
	assign in_susp = susp_s_r[1];
	// ***********************************************
	// pin synchronisers and source dividers
	// ***********************************************
	// two-stage sync of pins; edge taken from second stage only
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_s_r <= 2'b00;
			lfo_s_r <= 2'b00;
			ext_d_r <= 1'b0;
			lfo_d_r <= 1'b0;
			susp_s_r <= 2'b00;
			wko_s_r <= 2'b00;
			wko_d_r <= 1'b0;
		end else if (ce) begin
			ext_s_r <= {ext_s_r[0], ext_clk};
			lfo_s_r <= {lfo_s_r[0], lfo_clk};
			ext_d_r <= ext_s_r[1];
			lfo_d_r <= lfo_s_r[1];
			susp_s_r <= {susp_s_r[0], suspend};
			wko_s_r <= {wko_s_r[0], wake_other};
			wko_d_r <= wko_s_r[1];
		end
	end
	// prescalers: system_clock/12, and /8 on synchronised source edges
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div12_r <= 4'h0;
			ext_div_r <= 3'h0;
			lfo_div_r <= 3'h0;
		end else if (ce) begin
			div12_r <= (div12_r == `ART_DIV12_MAX) ? 4'h0 : div12_r + 4'h1;
			if (ext_s_r[1] & ~ext_d_r) begin
				ext_div_r <= ext_div_r + 3'h1;
			end
			if (lfo_s_r[1] & ~lfo_d_r) begin
				lfo_div_r <= lfo_div_r + 3'h1;
			end
		end
	end
	assign div12_tick = (div12_r == `ART_DIV12_MAX);
	assign ext8_tick = (ext_div_r == `ART_DIV8_MAX) & ext_s_r[1] & ~ext_d_r;
	assign lfo8_tick = (lfo_div_r == `ART_DIV8_MAX) & lfo_s_r[1] & ~lfo_d_r;
	// ***********************************************
	// per-half clock selection
	// ***********************************************
	// in 16-bit mode the low select also clocks the high byte
	art_tick u_tick_lo (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.sys_sel(clkctl_r[`ART_CK_LO]),
		.xsel(ctrl_r[`ART_CTL_XCLK_HI:`ART_CTL_XCLK_LO]),
		.div12_tick(div12_tick),
		.ext8_tick(ext8_tick),
		.lfo8_tick(lfo8_tick),
		.tick(tick_lo)
	);
	art_tick u_tick_hi (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.sys_sel(clkctl_r[`ART_CK_HI]),
		.xsel(ctrl_r[`ART_CTL_XCLK_HI:`ART_CTL_XCLK_LO]),
		.div12_tick(div12_tick),
		.ext8_tick(ext8_tick),
		.lfo8_tick(lfo8_tick),
		.tick(tick_hi)
	);
	// ***********************************************
	// counting and overflow
	// ***********************************************
	// split: low always runs, high gated by run bit
	assign lo_en = split ? tick_lo : (tick_lo & ctrl_r[`ART_CTL_RUN]);
	assign hi_en = split ? (tick_hi & ctrl_r[`ART_CTL_RUN]) : 1'b0;
	assign lo_wrap = lo_en & (cnt_lo_r == `ART_BYTE_ONES);
	assign full_wrap = ~split & lo_wrap & (cnt_hi_r == `ART_BYTE_ONES);
	assign hi_wrap = split ? (hi_en & (cnt_hi_r == `ART_BYTE_ONES)) : full_wrap;
	// counters; a bus write to a count byte yields to reload and to counting
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_lo_r <= `ART_ZERO8;
			cnt_hi_r <= `ART_ZERO8;
		end else if (ce) begin
			if (full_wrap) begin
				cnt_lo_r <= rld_lo_r;
				cnt_hi_r <= rld_hi_r;
			end else begin
				if (lo_wrap && split) begin
					cnt_lo_r <= rld_lo_r;
				end else if (lo_en) begin
					cnt_lo_r <= cnt_lo_r + 8'h01;
				end else if (wr && paddr == `ART_ADDR_CNT_LO) begin
					cnt_lo_r <= pwdata[7:0];
				end
				if (hi_wrap) begin
					cnt_hi_r <= rld_hi_r;
				end else if (hi_en || (lo_wrap && !split)) begin
					cnt_hi_r <= cnt_hi_r + 8'h01;
				end else if (wr && paddr == `ART_ADDR_CNT_HI) begin
					cnt_hi_r <= pwdata[7:0];
				end
			end
		end
	end
	// ***********************************************
	// control, flags and config registers
	// ***********************************************
	// flags set by hardware win over a software clear in the same cycle
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= `ART_CTL_RST;
			rld_lo_r <= `ART_ZERO8;
			rld_hi_r <= `ART_ZERO8;
			clkctl_r <= 2'b00;
			irqen_r <= 1'b0;
		end else if (ce) begin
			if (wr && paddr == `ART_ADDR_CTRL) begin
				ctrl_r <= pwdata[7:0];
			end
			if (hi_wrap) begin
				ctrl_r[`ART_CTL_HOF] <= 1'b1;
			end
			if (lo_wrap) begin
				ctrl_r[`ART_CTL_LOF] <= 1'b1;
			end
			if (wr && paddr == `ART_ADDR_RLD_LO) begin
				rld_lo_r <= pwdata[7:0];
			end
			if (wr && paddr == `ART_ADDR_RLD_HI) begin
				rld_hi_r <= pwdata[7:0];
			end
			if (wr && paddr == `ART_ADDR_CLKCTL) begin
				clkctl_r <= pwdata[1:0];
			end
			if (wr && paddr == `ART_ADDR_IRQEN) begin
				irqen_r <= pwdata[`ART_IE_TMR];
			end
		end
	end
	// ***********************************************
	// interrupt, wake and sync-busy
	// ***********************************************
	// irq level follows pending flags; low flag only with its enable
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_r <= 1'b0;
			wake_r <= 1'b0;
			sync_cnt_r <= 2'h0;
		end else if (ce) begin
			irq_r <= irqen_r & (ctrl_r[`ART_CTL_HOF] | hi_wrap |
				(ctrl_r[`ART_CTL_LOIEN] & (ctrl_r[`ART_CTL_LOF] | lo_wrap)));
			wake_r <= in_susp & hi_wrap;
			if (in_susp) begin
				sync_cnt_r <= 2'h0;
			end else if (wko_s_r[1] & ~wko_d_r) begin
				sync_cnt_r <= `ART_SYNC_CLKS;
			end else if (sync_cnt_r != 2'h0 && (tick_lo | tick_hi)) begin
				sync_cnt_r <= sync_cnt_r - 2'h1;
			end
		end
	end
	// ***********************************************
	// apb slave: zero wait, error on unmapped address
	// ***********************************************
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `ART_ZERO32;
		end else if (ce) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped(paddr);
			prdata <= `ART_ZERO32;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`ART_ADDR_CTRL: prdata <= {24'h000000, ctrl_r};
					`ART_ADDR_CNT_LO: prdata <= {24'h000000, cnt_lo_r};
					`ART_ADDR_CNT_HI: prdata <= {24'h000000, cnt_hi_r};
					`ART_ADDR_RLD_LO: prdata <= {24'h000000, rld_lo_r};
					`ART_ADDR_RLD_HI: prdata <= {24'h000000, rld_hi_r};
					`ART_ADDR_CLKCTL: prdata <= {30'h0, clkctl_r};
					`ART_ADDR_IRQEN: prdata <= {31'h0, irqen_r};
					`ART_ADDR_STATUS: prdata <= {30'h0, in_susp, sync_cnt_r != 2'h0};
					default: prdata <= `ART_ZERO32;
				endcase
			end
		end
	end
endmodule

// >>> art_timer_props.sv
// assertions on the timer bus handshake and reset outputs
`timescale 1ns/10ps
module art_timer_props (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire irq_r,
	input wire wake_r
);
	// ****************
	// bus handshake
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready && ce |=> !pready)
		else $error("ready held too long");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_no_ready_setup: assert property (psel && !penable |-> !pready)
		else $error("ready in setup cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_upper_bits_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_release_quiet: assert property ($rose(nrst) |-> !pready && !irq_r && !wake_r)
		else $error("output active after reset");
endmodule
bind art_timer art_timer_props props_u (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_r(irq_r), .wake_r(wake_r));

// >>> art_timer_tb.sv
// self-checking bench for the split-mode reload timer
`timescale 1ns/10ps
`include "art_map.vh"
module art_timer_tb;
	logic clk, nrst, psel, penable, pwrite, ext_clk, suspend, wake_other;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, irq_r, wake_r, err;
	int n_mismatch, comparisons, i;
	logic [11:0] ra [7];
	logic [31:0] rw [7];
	logic [31:0] re [7];
	art_timer dut_u (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_clk(ext_clk), .lfo_clk(ext_clk), .suspend(suspend), .wake_other(wake_other),
		.irq_r(irq_r), .wake_r(wake_r));
	// ****************
	// clocks and helpers
	// ****************
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// slow pin clock, 22 ns period against the 4 ns system clock
	initial begin
		ext_clk = 0;
		forever #11 ext_clk = ~ext_clk;
	end
	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic hang();
		n_mismatch++;
		$display("BAD %0t wait ran out", $time);
		give_verdict();
	endtask
	// one apb transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (pready !== 1'b1) hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read control until bit b is set
	task automatic poll(input int b);
		int j;
		for (j = 0; j < 300; j++) begin
			apb(0, `ART_ADDR_CTRL, 0);
			if (rd[b] === 1'b1) break;
		end
		if (rd[b] !== 1'b1) hang();
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		n_mismatch = 0;
		comparisons = 0;
		nrst = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		suspend = 0;
		wake_other = 0;
		ra = '{`ART_ADDR_RLD_LO, `ART_ADDR_RLD_HI, `ART_ADDR_CLKCTL, `ART_ADDR_IRQEN, `ART_ADDR_CNT_HI,
			`ART_ADDR_CNT_LO, 12'h020};
		rw = '{32'hF0, 32'hFF, 32'h03, 32'h01, 32'hFF, 32'hFE, 32'h77};
		re = '{32'hF0, 32'hFF, 32'h03, 32'h01, 32'hFF, 32'hFE, 32'h0};
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		for (i = 0; i < 8; i++) begin
			apb(0, 12'(i * 4), 0);
			check(rd, 0);
		end
		$display("reset values done");
		// rows: write, then read back
		for (i = 0; i < 7; i++) begin
			apb(1, ra[i], rw[i]);
			check({31'h0, err}, {31'h0, ra[i] == 12'h020});
			apb(0, ra[i], 0);
			check(rd, re[i]);
		end
		$display("register rows done");
		// full overflow reloads FFF0 and interrupts
		apb(1, `ART_ADDR_CTRL, 32'h04);
		poll(7);
		check({31'h0, irq_r}, 1);
		apb(0, `ART_ADDR_CNT_HI, 0);
		check(rd, 32'hFF);
		apb(1, `ART_ADDR_CTRL, 32'h00);
		repeat (3) @(posedge clk);
		check({31'h0, irq_r}, 0);
		$display("full overflow done");
		// split: low runs alone, high stopped
		apb(1, `ART_ADDR_CTRL, 32'h08);
		poll(6);
		check({31'h0, rd[7]}, 0);
		check({31'h0, irq_r}, 0);
		apb(0, `ART_ADDR_CNT_LO, 0);
		check(rd & 32'hF0, 32'hF0);
		apb(1, `ART_ADDR_CTRL, 32'h28);
		poll(6);
		check({31'h0, irq_r}, 1);
		apb(1, `ART_ADDR_CTRL, 32'h0C);
		poll(7);
		check({31'h0, irq_r}, 1);
		apb(0, `ART_ADDR_CNT_HI, 0);
		check(rd, 32'hFF);
		$display("split mode done");
		// overflow in suspend raises wake
		apb(1, `ART_ADDR_CTRL, 32'h00);
		suspend <= 1'b1;
		apb(1, `ART_ADDR_CTRL, 32'h04);
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			if (wake_r === 1'b1) break;
		end
		check({31'h0, wake_r}, 1);
		suspend <= 1'b0;
		apb(1, `ART_ADDR_CTRL, 32'h00);
		$display("suspend wake done");
		// other wake source on the div12 clock
		apb(1, `ART_ADDR_CLKCTL, 32'h00);
		wake_other <= 1'b1;
		repeat (6) @(posedge clk);
		apb(0, `ART_ADDR_STATUS, 0);
		check({31'h0, rd[0]}, 1);
		repeat (80) @(posedge clk);
		apb(0, `ART_ADDR_STATUS, 0);
		check({31'h0, rd[0]}, 0);
		$display("sync busy done");
		// split low half on the external pin divided by eight
		apb(1, `ART_ADDR_CNT_LO, 32'hFF);
		apb(1, `ART_ADDR_CTRL, 32'h09);
		poll(6);
		check({31'h0, rd[6]}, 1);
		check({31'h0, rd[7]}, 0);
		// low oscillator source; pin stands in for the oscillator, divided by eight
		apb(1, `ART_ADDR_CTRL, 32'h00);
		apb(1, `ART_ADDR_CNT_LO, 32'hFF);
		apb(1, `ART_ADDR_CTRL, 32'h0B);
		poll(6);
		check({31'h0, rd[6]}, 1);
		apb(1, `ART_ADDR_CTRL, 32'h00);
		$display("pin sources done");
		// reset in mid-run clears control
		apb(1, `ART_ADDR_CTRL, 32'h0C);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		apb(0, `ART_ADDR_CTRL, 0);
		check(rd, 0);
		$display("mid-run reset done");
		give_verdict();
	end
endmodule
